// ==== hw/sspms_core.sv ====
// synchronous master/slave serial port with register port and two-entry receive fifo
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/100ps

module sspms_core (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic [2:0]  addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [7:0]  rdata_out,
    input  wire logic        serial_clock_pin_in,
    output logic             serial_clock_pin_out,
    output logic             serial_clock_pin_oe_out,
    input  wire logic        serial_data_pin_in,
    output logic             serial_data_pin_out,
    output logic             serial_data_pin_oe_out,
    output logic             wake_out,
    output logic             irq_vector_out
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]       pie;
        logic [7:0]       pir_rest;
        logic             port_enable;
        logic             rx9;
        logic             single_receive_enable;
        logic             continuous_receive_enable;
        logic             address_detect_enable;
        logic             overrun_error_flag;
        logic [7:0]       brg;
        logic [7:0]       transmit_data_buffer;
        logic             txfull;
        logic             clock_source_master;
        logic             tx9;
        logic             transmit_enable;
        logic             sync;
        logic             high_speed_baud_select;
        logic             transmit_ninth_bit;
        logic             global_irq_enable;
        logic             peripheral_irq_enable;
        logic             slp;
        logic [8:0]       transmit_shifter;
        logic [3:0]       tx_left;
        logic [8:0]       receive_shifter;
        logic [3:0]       rx_cnt;
        logic [1:0][8:0]  fifo;
        logic             head;
        logic [1:0]       count;
        logic [7:0]       baud;
        logic             sclk;
        logic             dout;
        logic [7:0]       rdata;
        logic             ck_s1;
        logic             ck_s2;
        logic             ck_s3;
        logic             dt_s1;
        logic             dt_s2;
    } sspms_state_type;

    sspms_state_type          st;
    sspms_state_type          next_st;
    sspms_pkg::sspms_mode_type mode;
    logic                     master;
    logic                     rx_go;
    logic                     rx_active;
    logic                     tx_mode;
    logic                     master_run;
    logic                     tick;
    logic                     lead;
    logic                     trail;
    logic                     rx_done;
    logic                     pop;
    logic                     receive_ready_flag;
    logic                     transmit_buffer_free_flag;
    logic                     shift_empty_status;
    logic [3:0]               nbits_rx;

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    always_comb begin
        if (!(st.sync && st.port_enable)) begin
            mode = sspms_pkg::SSPMS_IDLE;
        end else if (st.clock_source_master) begin
            mode = (st.single_receive_enable || st.continuous_receive_enable) ? sspms_pkg::SSPMS_MRX : sspms_pkg::SSPMS_MTX;
        end else begin
            mode = (st.single_receive_enable || st.continuous_receive_enable) ? sspms_pkg::SSPMS_SRX : sspms_pkg::SSPMS_STX;
        end
    end

    // overrun blocks reception until the error is gone
    assign rx_go      = (st.single_receive_enable || st.continuous_receive_enable) && !st.overrun_error_flag;
    assign master     = (mode == sspms_pkg::SSPMS_MTX) || (mode == sspms_pkg::SSPMS_MRX);
    assign rx_active  = ((mode == sspms_pkg::SSPMS_MRX) || (mode == sspms_pkg::SSPMS_SRX))
                        && rx_go;
    assign tx_mode    = ((mode == sspms_pkg::SSPMS_MTX) || (mode == sspms_pkg::SSPMS_STX))
                        && st.transmit_enable;
    // master clock runs only while a character is in flight
    assign master_run = ((mode == sspms_pkg::SSPMS_MTX) && st.tx_left != 4'h0) ||
                        ((mode == sspms_pkg::SSPMS_MRX) && rx_go);
    assign tick       = master_run && (st.baud == st.brg);
    // edges from own divider as master, from the synchronised pin as slave
    assign lead       = master ? (tick && !st.sclk) : (st.ck_s2 && !st.ck_s3);
    assign trail      = master ? (tick && st.sclk) : (!st.ck_s2 && st.ck_s3);
    assign nbits_rx   = st.rx9 ? sspms_pkg::BITS_9 : sspms_pkg::BITS_8;
    assign rx_done    = rx_active && trail && ((st.rx_cnt + 4'h1) == nbits_rx);
    assign pop        = rd_in && (addr_in == sspms_pkg::OFS_RECEIVE_DATA_BUFFER) && (st.count != 2'h0);
    assign receive_ready_flag       = (st.count != 2'h0);
    assign transmit_buffer_free_flag       = st.port_enable && st.transmit_enable && !st.txfull;
    assign shift_empty_status       = (st.tx_left == 4'h0);

    // ------------------------------------------------------------------
    // read data mux
    // ------------------------------------------------------------------
    function automatic logic [7:0] read_value(input logic [2:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            sspms_pkg::OFS_PERIPHERAL_IRQ_ENABLE_1:  v = st.pie;
            sspms_pkg::OFS_PERIPHERAL_IRQ_FLAG_1: begin
                v = st.pir_rest;
                v[sspms_pkg::IRQ_RC] = receive_ready_flag;
                v[sspms_pkg::IRQ_TX] = transmit_buffer_free_flag;
            end
            sspms_pkg::OFS_RECEIVE_STATUS_CONTROL: v = {st.port_enable, st.rx9, st.single_receive_enable, st.continuous_receive_enable, st.address_detect_enable,
                                       1'b0, st.overrun_error_flag, st.fifo[st.head][8]};
            sspms_pkg::OFS_BRG:   v = st.brg;
            sspms_pkg::OFS_TRANSMIT_STATUS_CONTROL: v = {st.clock_source_master, st.tx9, st.transmit_enable, st.sync, 1'b0,
                                       st.high_speed_baud_select, shift_empty_status, st.transmit_ninth_bit};
            sspms_pkg::OFS_RECEIVE_DATA_BUFFER: v = st.fifo[st.head][7:0];
            sspms_pkg::OFS_CORE:  v = {5'h00, st.slp, st.peripheral_irq_enable, st.global_irq_enable};
            default:              v = 8'h00;                            // write-only buffer
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [8:0] chr;
        logic       idx;
        chr     = 9'h000;
        idx     = 1'b0;
        next_st = st;
        // pins pass two flops before anything reads them
        next_st.ck_s1 = serial_clock_pin_in;
        next_st.ck_s2 = st.ck_s1;
        next_st.ck_s3 = st.ck_s2;
        next_st.dt_s1 = serial_data_pin_in;
        next_st.dt_s2 = st.dt_s1;
        if (rd_in) begin
            next_st.rdata = read_value(addr_in);
        end
        // software writes
        if (wr_in) begin
            case (addr_in)
                sspms_pkg::OFS_PERIPHERAL_IRQ_ENABLE_1:  next_st.pie = wdata_in;
                sspms_pkg::OFS_PERIPHERAL_IRQ_FLAG_1:  next_st.pir_rest = wdata_in & 8'hCF;
                sspms_pkg::OFS_RECEIVE_STATUS_CONTROL: begin
                    next_st.port_enable  = wdata_in[sspms_pkg::RC_PORT_ENABLE];
                    next_st.rx9   = wdata_in[sspms_pkg::RC_RX9];
                    next_st.single_receive_enable  = wdata_in[sspms_pkg::RC_SINGLE_RECEIVE_ENABLE];
                    next_st.continuous_receive_enable  = wdata_in[sspms_pkg::RC_CONTINUOUS_RECEIVE_ENABLE];
                    next_st.address_detect_enable = wdata_in[sspms_pkg::RC_ADDRESS_DETECT_ENABLE];
                    if (st.continuous_receive_enable && !wdata_in[sspms_pkg::RC_CONTINUOUS_RECEIVE_ENABLE]) begin
                        next_st.overrun_error_flag = 1'b0;
                    end
                end
                sspms_pkg::OFS_BRG:   next_st.brg = wdata_in;
                sspms_pkg::OFS_TRANSMIT_DATA_BUFFER: begin
                    next_st.transmit_data_buffer  = wdata_in;
                    next_st.txfull = 1'b1;
                end
                sspms_pkg::OFS_TRANSMIT_STATUS_CONTROL: begin
                    next_st.clock_source_master = wdata_in[sspms_pkg::TX_CLOCK_SOURCE_MASTER];
                    next_st.tx9  = wdata_in[sspms_pkg::TX_TX9];
                    next_st.transmit_enable = wdata_in[sspms_pkg::TX_TRANSMIT_ENABLE];
                    next_st.sync = wdata_in[sspms_pkg::TX_SYNC];
                    next_st.high_speed_baud_select = wdata_in[sspms_pkg::TX_HIGH_SPEED_BAUD_SELECT];
                    next_st.transmit_ninth_bit = wdata_in[sspms_pkg::TX_TRANSMIT_NINTH_BIT];
                end
                sspms_pkg::OFS_CORE: begin
                    next_st.global_irq_enable  = wdata_in[sspms_pkg::CORE_GIE];
                    next_st.peripheral_irq_enable = wdata_in[sspms_pkg::CORE_PERIPHERAL_IRQ_ENABLE];
                    next_st.slp  = wdata_in[sspms_pkg::CORE_SLEEP];
                end
                default: next_st.pie = st.pie;
            endcase
        end
        // data read pops the fifo; in single mode it also ends an overrun
        if (pop) begin
            next_st.head  = ~st.head;
            next_st.count = st.count - 2'h1;
        end
        if (rd_in && (addr_in == sspms_pkg::OFS_RECEIVE_DATA_BUFFER) && !st.continuous_receive_enable) begin
            next_st.overrun_error_flag = 1'b0;
        end
        // master clock divider; low and still whenever nothing is in flight
        if (master_run) begin
            next_st.baud = tick ? 8'h00 : (st.baud + 8'h01);
            if (tick) begin
                next_st.sclk = ~st.sclk;
            end
        end else begin
            next_st.baud = 8'h00;
            next_st.sclk = 1'b0;
        end
        // transmit shifter
        if (!tx_mode) begin
            next_st.tx_left = 4'h0;
        end else if (st.tx_left != 4'h0) begin
            if (lead) begin
                next_st.dout = st.transmit_shifter[0];
            end
            if (trail) begin
                next_st.transmit_shifter     = {1'b0, st.transmit_shifter[8:1]};
                next_st.tx_left = st.tx_left - 4'h1;
            end
        end else if (st.txfull) begin
            next_st.transmit_shifter     = {st.transmit_ninth_bit, st.transmit_data_buffer};
            next_st.tx_left = st.tx9 ? sspms_pkg::BITS_9 : sspms_pkg::BITS_8;
            if (!(wr_in && addr_in == sspms_pkg::OFS_TRANSMIT_DATA_BUFFER)) begin
                next_st.txfull = 1'b0;
            end
        end
        // receive shifter; a dropped enable discards the partial character
        if (!rx_active) begin
            next_st.rx_cnt = 4'h0;
        end else if (trail) begin
            next_st.receive_shifter    = {st.dt_s2, st.receive_shifter[8:1]};
            next_st.rx_cnt = st.rx_cnt + 4'h1;
        end
        if (rx_done) begin
            next_st.rx_cnt = 4'h0;
            chr = st.rx9 ? next_st.receive_shifter : {1'b0, next_st.receive_shifter[8:1]};
            next_st.single_receive_enable = 1'b0;
            if (next_st.count == 2'h2) begin
                next_st.overrun_error_flag = 1'b1;
            end else begin
                idx = next_st.head ^ next_st.count[0];
                next_st.fifo[idx] = chr;
                next_st.count     = next_st.count + 2'h1;
            end
        end
        // port disable resets the serial unit's counters, flags, fifo pointers and clock divider
        if (!next_st.port_enable) begin
            next_st.tx_left = 4'h0;
            next_st.txfull  = 1'b0;
            next_st.rx_cnt  = 4'h0;
            next_st.count   = 2'h0;
            next_st.head    = 1'b0;
            next_st.overrun_error_flag    = 1'b0;
            next_st.sclk    = 1'b0;
            next_st.baud    = 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // registers and outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_out               = st.rdata;
    assign serial_clock_pin_out    = st.sclk;
    assign serial_clock_pin_oe_out = master;
    assign serial_data_pin_out     = st.dout;
    assign serial_data_pin_oe_out  = tx_mode;
    // either enabled flag in sleep wakes the core if the peripheral enable is set; only the global enable vectors
    assign wake_out       = st.slp && st.peripheral_irq_enable &&
                            ((transmit_buffer_free_flag && st.pie[sspms_pkg::IRQ_TX]) ||
                             (receive_ready_flag && st.pie[sspms_pkg::IRQ_RC]));
    assign irq_vector_out = wake_out && st.global_irq_enable;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    AST_MRX_NO_DRIVE: assert property (
        (mode == sspms_pkg::SSPMS_MRX) |-> !serial_data_pin_oe_out)
        else $error("data pin driven during master receive");
    AST_SINGLE_CLEAR: assert property (
        (rx_done && !st.continuous_receive_enable) |=> !st.single_receive_enable && (mode != sspms_pkg::SSPMS_MRX || !master_run))
        else $error("single receive did not clear after one character");
    AST_CONTINUOUS_RECEIVE_ENABLE_STOP: assert property (
        (st.clock_source_master && $fell(st.continuous_receive_enable) && !st.single_receive_enable) |=> !st.sclk && st.rx_cnt == 4'h0)
        else $error("clock kept running after continuous receive cleared");
    AST_SAMPLE: assert property (
        (rx_active && trail) |=> st.receive_shifter[8] == $past(st.dt_s2))
        else $error("receive shifter missed the trailing-edge sample");
    AST_PUSH: assert property (
        (rx_done && st.count == 2'h0 && !pop) |=> receive_ready_flag && st.count == 2'h1)
        else $error("finished character not queued");
    AST_OVERRUN: assert property (
        (rx_done && st.count == 2'h2 && !pop && st.port_enable) |=> st.overrun_error_flag && $stable(st.fifo))
        else $error("overrun not flagged or fifo overwritten");
    AST_PORT_ENABLE_RESET: assert property (
        !st.port_enable |-> st.count == 2'h0 && !st.overrun_error_flag && st.tx_left == 4'h0)
        else $error("serial unit not reset while port disabled");
    AST_SLAVE_CLK: assert property (
        !st.clock_source_master |-> !serial_clock_pin_oe_out)
        else $error("clock pin driven in slave mode");
    AST_TX_HOLD: assert property (
        (st.tx_left != 4'h0 && st.txfull && tx_mode) |-> !transmit_buffer_free_flag ##1 (st.txfull || st.tx_left != 4'h0))
        else $error("transmit flag set while a word still waits");
    AST_LOAD: assert property (
        (tx_mode && shift_empty_status && st.txfull && st.port_enable) |=> !shift_empty_status)
        else $error("buffered character not moved to the shifter");

    COV_SINGLE_RX: cover property (rx_done && !st.continuous_receive_enable ##1 !st.single_receive_enable);
    COV_OVERRUN:   cover property (rx_done && st.count == 2'h2 ##1 st.overrun_error_flag);
    COV_TX_QUEUE:  cover property (st.txfull && st.tx_left != 4'h0 ##[1:400] shift_empty_status);

endmodule

// ==== hw/sspms_pkg.sv ====
// constants, register map and mode type of the synchronous serial port
package sspms_pkg;

    // ------------------------------------------------------------------
    // register bus widths and offsets
    // ------------------------------------------------------------------
    localparam int          ADDR_W       = 3;
    localparam int          DATA_W       = 8;
    localparam logic [2:0]  OFS_PERIPHERAL_IRQ_ENABLE_1     = 3'h0;   // peripheral_irq_enable_1
    localparam logic [2:0]  OFS_PERIPHERAL_IRQ_FLAG_1     = 3'h1;   // peripheral_irq_flag_1
    localparam logic [2:0]  OFS_RECEIVE_STATUS_CONTROL    = 3'h2;   // receive_status_control
    localparam logic [2:0]  OFS_BRG      = 3'h3;   // baud_divisor
    localparam logic [2:0]  OFS_TRANSMIT_DATA_BUFFER    = 3'h4;   // transmit_data_buffer
    localparam logic [2:0]  OFS_TRANSMIT_STATUS_CONTROL    = 3'h5;   // transmit_status_control
    localparam logic [2:0]  OFS_RECEIVE_DATA_BUFFER    = 3'h6;   // receive_data_buffer
    localparam logic [2:0]  OFS_CORE     = 3'h7;   // core_control

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int          IRQ_RC       = 5;      // receive enable / ready flag
    localparam int          IRQ_TX       = 4;      // transmit enable / free flag
    localparam int          RC_PORT_ENABLE      = 7;
    localparam int          RC_RX9       = 6;
    localparam int          RC_SINGLE_RECEIVE_ENABLE      = 5;
    localparam int          RC_CONTINUOUS_RECEIVE_ENABLE      = 4;
    localparam int          RC_ADDRESS_DETECT_ENABLE     = 3;
    localparam int          TX_CLOCK_SOURCE_MASTER      = 7;
    localparam int          TX_TX9       = 6;
    localparam int          TX_TRANSMIT_ENABLE      = 5;
    localparam int          TX_SYNC      = 4;
    localparam int          TX_HIGH_SPEED_BAUD_SELECT      = 2;
    localparam int          TX_TRANSMIT_NINTH_BIT      = 0;
    localparam int          CORE_GIE     = 0;
    localparam int          CORE_PERIPHERAL_IRQ_ENABLE    = 1;
    localparam int          CORE_SLEEP   = 2;

    // ------------------------------------------------------------------
    // reset values and character lengths
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_REG      = 8'h00;
    localparam logic [7:0]  RST_TRANSMIT_STATUS_CONTROL    = 8'h02;  // shift register empty
    localparam logic [3:0]  BITS_8       = 4'h8;
    localparam logic [3:0]  BITS_9       = 4'h9;

    typedef enum logic [2:0] {
        SSPMS_IDLE,
        SSPMS_MTX,
        SSPMS_MRX,
        SSPMS_STX,
        SSPMS_SRX
    } sspms_mode_type;

endpackage

// ==== tb/sspms_peer.sv ====
// far-end peer model: clock source in slave modes, data source and bit logger
`timescale 1ns/100ps
module sspms_peer (
    input  wire logic       ck_ln_in,
    input  wire logic       dt_ln_in,
    input  wire logic       drive_in,
    input  wire logic [8:0] word_in,
    output logic            ck_out,
    output logic            dt_out
);
    int   idx = 0;
    logic got[$];
    initial ck_out = 1'b0;
    initial dt_out = 1'b0;

    // -----------------------------------------------------------------
    // data side
    // -----------------------------------------------------------------
    // next bit only on a leading edge, lsb first, ninth bit last
    always @(posedge ck_ln_in) begin
        if (drive_in) begin
            dt_out <= word_in[idx];
            idx    <= (idx == 8) ? 0 : idx + 1;
        end
    end
    // dropping drive restarts the next frame at bit zero
    always @(negedge drive_in) idx <= 0;
    // log the wire at every trailing edge, also counts the clocks seen
    always @(negedge ck_ln_in) got.push_back(dt_ln_in);

    // clock stands low between frames; odd start offset keeps it unrelated to clk_in
    task automatic run_clocks(input int n);
        #13;
        repeat (n) begin
            #160 ck_out = 1'b1;
            #160 ck_out = 1'b0;
        end
    endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench: register tasks, master and slave transfers against the peer
`timescale 1ns/100ps
module testbench;
    logic       clk_in    = 1'b0;
    logic       rstn_in   = 1'b0;
    logic       wr_in     = 1'b0;
    logic       rd_in     = 1'b0;
    logic [2:0] addr_in   = 3'h0;
    logic [7:0] wdata_in  = 8'h00;
    logic [8:0] word      = 9'h000;
    logic       drive     = 1'b0;
    logic       dt_last   = 1'b0;
    logic [7:0] rdata_out, d;
    logic       ck_o, ck_oe, dt_o, dt_oe, wake, vec, peer_ck, peer_dt;
    int         err_total = 0;
    int         checked   = 0;
    int         n;
    // wire levels; a released data line shows a changing pattern, never a held value
    wire        ck_ln     = ck_oe ? ck_o : peer_ck;
    wire        dt_ln     = dt_oe ? dt_o : (drive ? peer_dt : ~dt_last);

    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) dt_last <= dt_ln;

    sspms_core dut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .serial_clock_pin_in(ck_ln),
        .serial_clock_pin_out(ck_o), .serial_clock_pin_oe_out(ck_oe), .serial_data_pin_in(dt_ln),
        .serial_data_pin_out(dt_o), .serial_data_pin_oe_out(dt_oe), .wake_out(wake),
        .irq_vector_out(vec));
    sspms_peer peer (.ck_ln_in(ck_ln), .dt_ln_in(dt_ln), .drive_in(drive), .word_in(word),
        .ck_out(peer_ck), .dt_out(peer_dt));

    // -----------------------------------------------------------------
    // tasks
    // -----------------------------------------------------------------
    task automatic end_of_test();
        $display("mismatches %0d, comparisons %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // strobes drop one edge before the next access, so no signal is set twice in a step
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        addr_in  <= a;
        wdata_in <= v;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [2:0] a);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(posedge clk_in);
        d = rdata_out;
    endtask
    // bounded poll of masked register bits; running out ends the run
    task automatic poll(input logic [2:0] a, input logic [7:0] m, input logic [7:0] v);
        for (n = 0; n < 3000; n++) begin
            rd(a);
            if ((d & m) === v) return;
        end
        err_total++;
        $display("MISMATCH at %0t: poll timed out", $time);
        end_of_test();
    endtask
    // character k of the logged bits, lsb first
    function automatic logic [8:0] lb(input int k, input int w);
        lb = 9'h000;
        for (int i = 0; i < w; i++) lb[i] = peer.got[k * w + i];
    endfunction

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            rd(3'(i));
            chk({1'b0, d}, (i == 5) ? 9'h002 : 9'h000);
        end
        // master transmit, second character written while the first still shifts
        // half period of four cycles leaves room for the two-flop data synchroniser
        wr(3'h3, 8'h03);
        wr(3'h2, 8'h80);
        wr(3'h5, 8'hb0);
        peer.got.delete();
        wr(3'h4, 8'ha5);
        wr(3'h4, 8'h3c);
        rd(3'h5);
        chk({8'h00, d[1]}, 9'h000);
        // the shifter is empty for one cycle between the two characters, so wait out both
        for (n = 0; n < 3000 && peer.got.size() < 16; n++) @(posedge clk_in);
        poll(3'h5, 8'h02, 8'h02);
        chk(9'(peer.got.size()), 9'h010);
        chk(lb(0, 8), 9'h0a5);
        chk(lb(1, 8), 9'h03c);
        // master single receive: one character of clocks, then the enable drops
        word  <= 9'h0c6;
        drive <= 1'b1;
        wr(3'h5, 8'h90);
        peer.got.delete();
        wr(3'h2, 8'ha0);
        chk({8'h00, dt_oe}, 9'h000);
        poll(3'h2, 8'h20, 8'h00);
        chk(9'(peer.got.size()), 9'h008);
        rd(3'h1);
        chk({8'h00, d[5]}, 9'h001);
        rd(3'h6);
        chk({1'b0, d}, 9'h0c6);
        rd(3'h1);
        chk({8'h00, d[5]}, 9'h000);
        // continuous nine-bit receive runs into overrun
        word  <= 9'h1c3;
        // drop and raise drive so the peer restarts its frame at bit zero
        drive <= 1'b0;
        @(posedge clk_in);
        drive <= 1'b1;
        @(posedge clk_in);
        peer.got.delete();
        wr(3'h2, 8'hd0);
        poll(3'h2, 8'h02, 8'h02);
        rd(3'h2);
        chk({8'h00, d[0]}, 9'h001);
        rd(3'h6);
        chk({1'b0, d}, 9'h0c3);
        rd(3'h1);
        chk({8'h00, d[5]}, 9'h001);
        rd(3'h6);
        chk({1'b0, d}, 9'h0c3);
        chk(9'(peer.got.size()), 9'h01b);
        wr(3'h2, 8'hc0);
        rd(3'h2);
        chk({1'b0, d & 8'hfe}, 9'h0c0);
        // continuous receive dropped after three bits: clock halts, partial bits lost
        peer.got.delete();
        wr(3'h2, 8'hd0);
        for (n = 0; n < 300 && peer.got.size() < 3; n++) @(posedge clk_in);
        wr(3'h2, 8'hc0);
        repeat (40) @(posedge clk_in);
        chk({7'h00, 1'(peer.got.size() < 5), ck_o}, 9'h002);
        rd(3'h1);
        chk({8'h00, d[5]}, 9'h000);
        // port disable clears a pending overrun
        wr(3'h2, 8'hd0);
        poll(3'h2, 8'h02, 8'h02);
        wr(3'h2, 8'h40);
        rd(3'h2);
        chk({1'b0, d & 8'hfe}, 9'h040);
        // slave transmit, two words queued after sleep is set, peer supplies the clock
        drive <= 1'b0;
        wr(3'h2, 8'h80);
        wr(3'h5, 8'h30);
        wr(3'h0, 8'h10);
        wr(3'h7, 8'h06);
        peer.got.delete();
        wr(3'h4, 8'h81);
        wr(3'h4, 8'h7e);
        rd(3'h1);
        chk({8'h00, d[4]}, 9'h000);
        chk({7'h00, ck_oe, wake}, 9'h000);
        peer.run_clocks(8);
        repeat (10) @(posedge clk_in);
        rd(3'h1);
        chk({8'h00, d[4]}, 9'h001);
        chk({7'h00, wake, vec}, 9'h002);
        wr(3'h7, 8'h07);
        chk({8'h00, vec}, 9'h001);
        peer.run_clocks(8);
        repeat (10) @(posedge clk_in);
        chk(lb(0, 8), 9'h081);
        chk(lb(1, 8), 9'h07e);
        end_of_test();
    end
endmodule
